// [sag_peak_defs.svh]
// Register offsets, field positions and shared constants for the sag and peak detector
`ifndef SAG_PEAK_DEFS_SVH
`define SAG_PEAK_DEFS_SVH

`define ADDR_CURRENT_PEAK 16'hE500
`define ADDR_VOLTAGE_PEAK 16'hE501
`define ADDR_SAG_LEVEL 16'hE509
`define ADDR_PHASE_STATUS 16'hE600
`define ADDR_MEAS_MODE 16'hE700
`define ADDR_ACCUM_MODE 16'hE701
`define ADDR_PEAK_CYC 16'hE703
`define ADDR_SAG_CYC 16'hE704
`define ADDR_EVENT_STATUS 16'hE5F0
`define ADDR_EVENT_MASK 16'hE5F1

`define STAT_SAG_BIT 16
`define STAT_PKI_BIT 23
`define STAT_PKV_BIT 24
`define FLAG_SAG 2
`define FLAG_PKI 1
`define FLAG_PKV 0

`define SAG_STYLE_BIT 6
`define PEAK_PHASE_SELECT_LSB 2
`define PEAK_PHASE_SELECT_MSB 4
`define PH_SAG_LSB 12
`define PEAK_PH_LSB 24

`define SAG_LVL_OFF 24'h000001
`define CNT_ZERO 8'h00
`define CNT_ONE 8'h01
`define READ_ZERO 32'h00000000

`endif

// [sag_peak_pkg.sv]
// Types shared by the sag and peak detector
`default_nettype none
package sag_peak_pkg;

    typedef struct packed {
        logic [26:0] ipk;
        logic [26:0] vpk;
        logic [23:0] sag_threshold_level;
        logic [7:0] measurement_mode_config;
        logic [7:0] accumulation_mode_config;
        logic [7:0] peak_halfcycle_count;
        logic [7:0] sag_halfcycle_count;
        logic [2:0] status;
        logic [2:0] mask;
        logic [2:0] sag_state;
        logic [2:0][7:0] sag_cnt;
        logic [2:0] below;
        logic [2:0] above;
        logic [7:0] pk_cnt;
        logic [23:0] imax;
        logic [2:0] iph;
        logic [23:0] vmax;
        logic [2:0] vph;
        logic [31:0] rdata;
        logic irq_n;
    } state_t;

endpackage
`default_nettype wire

// [sag_peak_detector.sv]
// Voltage sag detection and current/voltage peak capture with event interrupt
`timescale 1ns/1ps
`default_nettype none
`include "sag_peak_defs.svh"

// How it works
// [R1] Style 0: sag flag set when a phase stays below level a full period.
// [R2] Style 1: sag flag set only after a phase went below then rose above.
// [R3] Per-phase sag state bits 14..12 follow below/above over each period.
// [R4] Clearing the sag flag releases the interrupt, leaves phase sag bits alone.
// [R5] Style 0: another full period below sets the flag again.
// [R6] Style 1: staying below never re-flags; rising above flags and clears state.
// [R7] Period length is the 8-bit sag half-cycle count; zero disables.
// [R8] Masked sag flag pulls the interrupt low at once; write one clears.
// [R9] Half-cycle counter runs free; sag count write with level set restarts it.
// [R10] Level compared to absolute filter output; level 0 or 1 never triggers.
// [R11] Sag level reads back as 32 bits with upper eight bits zero.
// [R12] Max absolute current and voltage over the peak period kept in low 24 bits.
// [R13] Peak phase select bits 4..2 of mode register choose monitored phases.
// [R14] Zero crossings of every selected phase advance the peak counter.
// [R15] Bits 26..24 of each peak register mark the latest peak phase one-hot.
// [R16] Peak value and phase update at period end, then hold all next period.
// [R17] Period end sets current and voltage peak flags; masked flags interrupt.
// [R18] Peak count write with phases selected restarts the peak counter.
// [R19] Host sets style and mask, reads status then phase bits, then clears.
// [R20] Host reads the peak register right after status, then clears flag.
// [R21] Interrupt stays low while any masked flag is set.
// [R22] Each half line cycle counts on the phase zero-crossing pulse.
module sag_peak_detector (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [2:0][23:0] volt_hpf,
    input wire logic [2:0][23:0] curr_hpf,
    input wire logic [2:0] zx_volt,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic event_irq_line_n
);

    sag_peak_pkg::state_t q;
    sag_peak_pkg::state_t d;
    logic pk_end;
    logic sag_set;

    // Two's complement magnitude, saturating the most negative code
    function automatic logic [23:0] abs24(input logic [23:0] x);
        logic [23:0] r;
        r = x[23] ? (~x + 24'h000001) : x;
        if (r[23]) begin
            r = 24'h7FFFFF;
        end
        return r;
    endfunction

    function automatic logic [1:0] count3(input logic [2:0] x);
        return {1'b0, x[0]} + {1'b0, x[1]} + {1'b0, x[2]};
    endfunction

    // Flag triple placed at its event status bit positions
    function automatic logic [31:0] flags32(input logic [2:0] f);
        logic [31:0] r;
        r = `READ_ZERO;
        r[`STAT_SAG_BIT] = f[`FLAG_SAG];
        r[`STAT_PKI_BIT] = f[`FLAG_PKI];
        r[`STAT_PKV_BIT] = f[`FLAG_PKV];
        return r;
    endfunction

    logic wr_status;
    logic wr_sag_halfcycle_count;
    logic wr_peak_halfcycle_count;
    logic sag_on;
    logic [2:0] peak_sel;
    logic [1:0] zx_inc;

    assign wr_status = reg_wr && (reg_addr == `ADDR_EVENT_STATUS);
    assign wr_sag_halfcycle_count = reg_wr && (reg_addr == `ADDR_SAG_CYC);
    assign wr_peak_halfcycle_count = reg_wr && (reg_addr == `ADDR_PEAK_CYC);
    assign sag_on = (q.sag_threshold_level > `SAG_LVL_OFF) && (q.sag_halfcycle_count != `CNT_ZERO); // [R7] [R10]
    assign peak_sel = q.measurement_mode_config[`PEAK_PHASE_SELECT_MSB:`PEAK_PHASE_SELECT_LSB]; // [R13]
    assign zx_inc = count3(zx_volt & peak_sel); // [R14]

    always_comb begin
        logic [23:0] a;
        logic [8:0] pk_sum;
        d = q;
        sag_set = 1'b0;
        pk_end = 1'b0;
        a = 24'h000000;
        pk_sum = {1'b0, q.pk_cnt} + {7'h00, zx_inc};

        // Software writes; flag clears go first so a same-cycle event wins
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_SAG_LEVEL: begin
                    d.sag_threshold_level = reg_wdata[23:0];
                end
                `ADDR_MEAS_MODE: begin
                    d.measurement_mode_config = reg_wdata[7:0];
                end
                `ADDR_ACCUM_MODE: begin
                    d.accumulation_mode_config = reg_wdata[7:0];
                end
                `ADDR_PEAK_CYC: begin
                    d.peak_halfcycle_count = reg_wdata[7:0];
                end
                `ADDR_SAG_CYC: begin
                    d.sag_halfcycle_count = reg_wdata[7:0];
                end
                `ADDR_EVENT_STATUS: begin
                    d.status[`FLAG_SAG] = q.status[`FLAG_SAG] & ~reg_wdata[`STAT_SAG_BIT]; // [R4]
                    d.status[`FLAG_PKI] = q.status[`FLAG_PKI] & ~reg_wdata[`STAT_PKI_BIT];
                    d.status[`FLAG_PKV] = q.status[`FLAG_PKV] & ~reg_wdata[`STAT_PKV_BIT];
                end
                `ADDR_EVENT_MASK: begin
                    d.mask[`FLAG_SAG] = reg_wdata[`STAT_SAG_BIT];
                    d.mask[`FLAG_PKI] = reg_wdata[`STAT_PKI_BIT];
                    d.mask[`FLAG_PKV] = reg_wdata[`STAT_PKV_BIT];
                end
                default: begin
                    d.sag_threshold_level = q.sag_threshold_level;
                end
            endcase
        end

        // Sag tracking per phase
        for (int p = 0; p < 3; p++) begin
            a = abs24(volt_hpf[p]);
            if (sample_valid && sag_on) begin
                if (a < q.sag_threshold_level) begin // [R10]
                    d.above[p] = 1'b0;
                end else begin
                    d.below[p] = 1'b0;
                end
            end
            // Counter keeps running with the level off; only the verdict is gated
            if (zx_volt[p] && q.sag_halfcycle_count != `CNT_ZERO) begin // [R9] [R22]
                if (q.sag_cnt[p] >= q.sag_halfcycle_count - `CNT_ONE) begin // [R7]
                    d.sag_cnt[p] = `CNT_ZERO;
                    if (d.below[p] && sag_on) begin
                        d.sag_state[p] = 1'b1; // [R3]
                        if (!q.accumulation_mode_config[`SAG_STYLE_BIT]) begin
                            sag_set = 1'b1; // [R1] [R5]
                        end
                    end else if (d.above[p] && sag_on) begin
                        if (q.sag_state[p] && q.accumulation_mode_config[`SAG_STYLE_BIT]) begin
                            sag_set = 1'b1; // [R2] [R6]
                        end
                        d.sag_state[p] = 1'b0; // [R3] [R6]
                    end
                    d.below[p] = 1'b1;
                    d.above[p] = 1'b1;
                end else begin
                    d.sag_cnt[p] = q.sag_cnt[p] + `CNT_ONE; // [R9]
                end
            end
        end
        if (sag_set) begin
            d.status[`FLAG_SAG] = 1'b1; // [R8]
        end

        // Running peaks over selected phases
        for (int p = 0; p < 3; p++) begin
            if (sample_valid && peak_sel[p]) begin
                a = abs24(curr_hpf[p]);
                if (a > d.imax) begin
                    d.imax = a; // [R12]
                    d.iph = 3'(1 << p); // [R15]
                end
                a = abs24(volt_hpf[p]);
                if (a > d.vmax) begin
                    d.vmax = a; // [R12]
                    d.vph = 3'(1 << p); // [R15]
                end
            end
        end
        if (zx_inc != 2'b00 && q.peak_halfcycle_count != `CNT_ZERO) begin
            if (pk_sum >= {1'b0, q.peak_halfcycle_count}) begin
                pk_end = 1'b1;
                d.pk_cnt = `CNT_ZERO;
                d.ipk = {d.iph, d.imax}; // [R16]
                d.vpk = {d.vph, d.vmax}; // [R16]
                d.imax = 24'h000000;
                d.iph = 3'b000;
                d.vmax = 24'h000000;
                d.vph = 3'b000;
                d.status[`FLAG_PKI] = 1'b1; // [R17]
                d.status[`FLAG_PKV] = 1'b1; // [R17]
            end else begin
                d.pk_cnt = pk_sum[7:0]; // [R14]
            end
        end

        // Count restarts so the first result spans a full period
        if (wr_sag_halfcycle_count && q.sag_threshold_level != 24'h000000) begin
            d.sag_cnt = '0; // [R9]
            d.below = 3'b111;
            d.above = 3'b111;
        end
        if (wr_peak_halfcycle_count && peak_sel != 3'b000) begin
            d.pk_cnt = `CNT_ZERO; // [R18]
            d.imax = 24'h000000;
            d.iph = 3'b000;
            d.vmax = 24'h000000;
            d.vph = 3'b000;
        end

        // Read data is captured on the strobe and held
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CURRENT_PEAK: d.rdata = {5'h00, q.ipk}; // [R12]
                `ADDR_VOLTAGE_PEAK: d.rdata = {5'h00, q.vpk}; // [R12]
                `ADDR_SAG_LEVEL: d.rdata = {8'h00, q.sag_threshold_level}; // [R11]
                `ADDR_PHASE_STATUS: d.rdata = 32'(q.sag_state) << `PH_SAG_LSB; // [R3]
                `ADDR_MEAS_MODE: d.rdata = {24'h000000, q.measurement_mode_config};
                `ADDR_ACCUM_MODE: d.rdata = {24'h000000, q.accumulation_mode_config};
                `ADDR_PEAK_CYC: d.rdata = {24'h000000, q.peak_halfcycle_count};
                `ADDR_SAG_CYC: d.rdata = {24'h000000, q.sag_halfcycle_count};
                `ADDR_EVENT_STATUS: d.rdata = flags32(q.status);
                `ADDR_EVENT_MASK: d.rdata = flags32(q.mask);
                default: d.rdata = `READ_ZERO;
            endcase
        end

        // Line follows next flag state, so it falls with the flag edge
        d.irq_n = ~|(d.status & d.mask); // [R8] [R21]
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.irq_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign event_irq_line_n = q.irq_n;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    irq_follows_flags_a: assert property (q.irq_n == ~|(q.status & q.mask)) // [R21]
        else $error("interrupt line disagrees with masked flags");
    sag_flag_clear_a: assert property ( // [R8]
        wr_status && reg_wdata[`STAT_SAG_BIT] && !(|zx_volt) |=> !q.status[`FLAG_SAG])
        else $error("sag flag not cleared by write one");
    sag_state_keep_a: assert property ( // [R4]
        wr_status && !(|zx_volt) && !wr_sag_halfcycle_count |=> $stable(q.sag_state))
        else $error("status write disturbed phase sag bits");
    peak_hold_a: assert property (!pk_end |=> $stable(q.ipk) && $stable(q.vpk)) // [R16]
        else $error("peak register changed inside a period");
    peak_flags_a: assert property (pk_end |=> q.status[`FLAG_PKI] && q.status[`FLAG_PKV]) // [R17]
        else $error("peak flags not set at period end");
    peak_onehot_a: assert property ($onehot0(q.ipk[26:24]) && $onehot0(q.vpk[26:24])) // [R15]
        else $error("peak phase bits not one-hot");
    sag_zero_cyc_a: assert property (q.sag_halfcycle_count == `CNT_ZERO |=> $stable(q.sag_state)) // [R7]
        else $error("sag state moved with zero period");
    sag_never_a: assert property (q.sag_threshold_level <= `SAG_LVL_OFF |=> !$rose(q.status[`FLAG_SAG])) // [R10]
        else $error("sag flagged with level off");
    sag_cnt_rst_a: assert property ( // [R9]
        wr_sag_halfcycle_count && q.sag_threshold_level != 24'h000000 |=> q.sag_cnt == '0)
        else $error("sag counter not restarted");
    peak_cnt_rst_a: assert property ( // [R18]
        wr_peak_halfcycle_count && peak_sel != 3'b000 |=> q.pk_cnt == `CNT_ZERO)
        else $error("peak counter not restarted");

    // Sag verdicts, seen one sample after the edge that made them
    sag_cnt_idle_a: assert property ( // [R7]
        q.sag_halfcycle_count == `CNT_ZERO && !wr_sag_halfcycle_count |=> $stable(q.sag_cnt))
        else $error("sag counter ran with zero period");
    sag_style0_a: assert property ( // [R1] [R5]
        $rose(q.status[`FLAG_SAG]) && !$past(q.accumulation_mode_config[`SAG_STYLE_BIT]) |-> |q.sag_state)
        else $error("style 0 sag flag without a phase in sag");
    sag_style1_a: assert property ( // [R2] [R6]
        $rose(q.status[`FLAG_SAG]) && $past(q.accumulation_mode_config[`SAG_STYLE_BIT])
        |-> |($past(q.sag_state) & ~q.sag_state))
        else $error("style 1 sag flag without a phase leaving sag");
    sag_state_zx_a: assert property ( // [R22]
        q.sag_state != $past(q.sag_state) |-> |$past(zx_volt))
        else $error("phase sag bits moved away from a crossing");
    sag_irq_a: assert property ( // [R8]
        $rose(q.status[`FLAG_SAG]) && q.mask[`FLAG_SAG] |-> !q.irq_n)
        else $error("masked sag flag did not pull the line low");

    // Peak flags and values
    pk_irq_a: assert property ( // [R17]
        $rose(q.status[`FLAG_PKV]) && q.mask[`FLAG_PKV] |-> !q.irq_n)
        else $error("masked peak flag did not pull the line low");
    pk_flag_src_a: assert property ( // [R17]
        $rose(q.status[`FLAG_PKI]) || $rose(q.status[`FLAG_PKV]) |-> $past(pk_end))
        else $error("peak flag set outside a period end");
    pk_iclear_a: assert property ( // [R17]
        wr_status && reg_wdata[`STAT_PKI_BIT] && !pk_end |=> !q.status[`FLAG_PKI])
        else $error("current peak flag not cleared by write one");
    pk_vclear_a: assert property ( // [R17]
        wr_status && reg_wdata[`STAT_PKV_BIT] && !pk_end |=> !q.status[`FLAG_PKV])
        else $error("voltage peak flag not cleared by write one");
    pk_idle_a: assert property ( // [R17]
        q.peak_halfcycle_count == `CNT_ZERO |=> !$rose(q.status[`FLAG_PKV]))
        else $error("peak flag set with zero period");
    pk_sel_idle_a: assert property ( // [R13]
        peak_sel == 3'b000 |=> $stable(q.pk_cnt))
        else $error("peak counter moved with no phase selected");
    pk_phase_set_a: assert property ( // [R15]
        ((q.ipk[23:0] != 24'h000000) == (q.ipk[26:24] != 3'b000))
        && ((q.vpk[23:0] != 24'h000000) == (q.vpk[26:24] != 3'b000)))
        else $error("peak value and phase bits disagree");

    // Read path; a host may poll, so data must hold between strobes
    rdata_hold_a: assert property (!reg_rd |=> $stable(q.rdata)) // [R12]
        else $error("read data moved without a read strobe");
    lvl_read_a: assert property ( // [R11]
        reg_rd && reg_addr == `ADDR_SAG_LEVEL |=> q.rdata == {8'h00, $past(q.sag_threshold_level)})
        else $error("sag level read not zero padded");
    pk_read_pad_a: assert property ( // [R12]
        reg_rd && (reg_addr == `ADDR_CURRENT_PEAK || reg_addr == `ADDR_VOLTAGE_PEAK)
        |=> q.rdata[31:27] == 5'h00)
        else $error("peak read upper bits not zero");
    phase_read_a: assert property ( // [R3]
        reg_rd && reg_addr == `ADDR_PHASE_STATUS
        |=> q.rdata == (32'($past(q.sag_state)) << `PH_SAG_LSB))
        else $error("phase sag bits read at wrong place");
    status_read_a: assert property ( // [R17]
        reg_rd && reg_addr == `ADDR_EVENT_STATUS |=> q.rdata == {7'h00,
        $past(q.status[`FLAG_PKV]), $past(q.status[`FLAG_PKI]), 6'h00,
        $past(q.status[`FLAG_SAG]), 16'h0000})
        else $error("event status read at wrong bits");
    mask_read_a: assert property ( // [R8]
        reg_rd && reg_addr == `ADDR_EVENT_MASK |=> q.rdata == {7'h00,
        $past(q.mask[`FLAG_PKV]), $past(q.mask[`FLAG_PKI]), 6'h00,
        $past(q.mask[`FLAG_SAG]), 16'h0000})
        else $error("event mask read at wrong bits");

    sag_event_c: cover property ($rose(q.status[`FLAG_SAG]));
    peak_event_c: cover property ($rose(q.status[`FLAG_PKI]));
    irq_low_c: cover property ($fell(q.irq_n));
    sag_style1_c: cover property ($rose(q.status[`FLAG_SAG]) && q.accumulation_mode_config[`SAG_STYLE_BIT]);
    peak_two_phase_c: cover property (pk_end && zx_inc == 2'h2);

endmodule
`default_nettype wire

// [sag_host_model.sv]
// Host model that services the detector's event interrupt over the register port
`timescale 1ns/1ps
`default_nettype none
`include "sag_peak_defs.svh"
module sag_host_model (
    input wire logic ref_clk,
    input wire logic irq_n,
    input wire logic [31:0] rdata,
    output logic [15:0] addr,
    output logic wr,
    output logic rd,
    output logic [31:0] wdata
);
    initial begin
        addr = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h00000000;
    end
    task automatic put(input logic [15:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge ref_clk);
        wr = 1'b0;
        wdata = ~d;  // Stale data never looks valid
    endtask
    task automatic get(input logic [15:0] a, output logic [31:0] d);
        @(negedge ref_clk);
        addr = a;
        rd = 1'b1;
        @(negedge ref_clk);
        rd = 1'b0;
        d = rdata;
    endtask
    // Detail is read before clearing, though a clear leaves phase and peak bits alone
    task automatic service(input logic [15:0] detail, input logic [31:0] clr,
            output logic [31:0] st, output logic [31:0] info);
        get(`ADDR_EVENT_STATUS, st);
        get(detail, info);
        put(`ADDR_EVENT_STATUS, clr);
    endtask
endmodule
`default_nettype wire

// [voltage_sag_and_peak_detector_tb.sv]
// Self-checking bench for the sag and peak detector
`timescale 1ns/1ps
`default_nettype none
`include "sag_peak_defs.svh"
module voltage_sag_and_peak_detector_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b1;
    logic [2:0][23:0] volt_hpf = '0;
    logic [2:0][23:0] curr_hpf = '0;
    logic [2:0] zx_volt = 3'h0;
    logic [15:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] st;
    logic [31:0] info;
    logic event_irq_line_n;
    int bad_count = 0;
    int check_count = 0;

    sag_peak_detector u_dut (.ref_clk(ref_clk), .rst(rst), .sample_valid(sample_valid),
        .volt_hpf(volt_hpf), .curr_hpf(curr_hpf), .zx_volt(zx_volt), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .event_irq_line_n(event_irq_line_n));
    sag_host_model u_host (.ref_clk(ref_clk), .irq_n(event_irq_line_n), .rdata(reg_rdata),
        .addr(reg_addr), .wr(reg_wr), .rd(reg_rd), .wdata(reg_wdata));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One-cycle crossing pulses, n half cycles
    task zx(input logic [2:0] p, input int n);
        repeat (n) begin
            @(negedge ref_clk);
            zx_volt = p;
            @(negedge ref_clk);
            zx_volt = 3'h0;
        end
    endtask
    task test_regs;
        u_host.put(`ADDR_SAG_LEVEL, 32'hFFFFFFFF);
        u_host.get(`ADDR_SAG_LEVEL, st);
        chk("sag_level", st, 32'h00FFFFFF);
        u_host.get(16'hE5FF, st);
        chk("unmapped", st, 32'h00000000);
        u_host.put(`ADDR_EVENT_MASK, 32'hFFFFFFFF);
        u_host.get(`ADDR_EVENT_MASK, st);
        chk("mask", st, 32'h01810000);
        $display("test_regs done");
    endtask
    task test_sag0;
        volt_hpf = {24'h0003E8, 24'h0003E8, 24'hFFFFF6};
        u_host.put(`ADDR_SAG_LEVEL, 32'h00000064);
        u_host.put(`ADDR_EVENT_MASK, 32'h00010000);
        u_host.put(`ADDR_SAG_CYC, 32'h2);
        zx(3'h7, 1);
        chk("irq_early", event_irq_line_n, 1'b1);
        zx(3'h7, 1);
        chk("irq_sag", event_irq_line_n, 1'b0);
        u_host.service(`ADDR_PHASE_STATUS, 32'h00010000, st, info);
        chk("status", st, 32'h00010000);
        chk("phase", info, 32'h00001000);
        chk("irq_clr", event_irq_line_n, 1'b1);
        u_host.get(`ADDR_PHASE_STATUS, st);
        chk("phase_kept", st, 32'h00001000);
        zx(3'h7, 2);
        chk("irq_again", event_irq_line_n, 1'b0);
        u_host.service(`ADDR_PHASE_STATUS, 32'h00010000, st, info);
        volt_hpf[0] = 24'h0001F4;
        // First period is mixed and changes nothing; the second is fully above
        zx(3'h7, 4);
        u_host.get(`ADDR_PHASE_STATUS, st);
        chk("phase_up", st, 32'h0);
        chk("irq_up", event_irq_line_n, 1'b1);
        volt_hpf[0] = 24'h0;
        u_host.put(`ADDR_SAG_LEVEL, 32'h1);
        u_host.put(`ADDR_SAG_CYC, 32'h2);
        zx(3'h7, 2);
        chk("irq_lvl1", event_irq_line_n, 1'b1);
        $display("test_sag0 done");
    endtask
    task test_sag1;
        volt_hpf[0] = 24'hFFFFF6;
        u_host.put(`ADDR_ACCUM_MODE, 32'h40);
        u_host.put(`ADDR_SAG_LEVEL, 32'h00000064);
        u_host.put(`ADDR_SAG_CYC, 32'h2);
        zx(3'h7, 2);
        chk("irq_below", event_irq_line_n, 1'b1);
        u_host.get(`ADDR_PHASE_STATUS, st);
        chk("phase1", st, 32'h00001000);
        zx(3'h7, 2);
        chk("irq_still", event_irq_line_n, 1'b1);
        volt_hpf[0] = 24'h0001F4;
        zx(3'h7, 2);
        chk("irq_rise", event_irq_line_n, 1'b0);
        u_host.service(`ADDR_PHASE_STATUS, 32'h00010000, st, info);
        chk("event_status_second", st, 32'h00010000);
        chk("phase1_clr", info, 32'h0);
        $display("test_sag1 done");
    endtask
    task test_peak;
        u_host.put(`ADDR_SAG_LEVEL, 32'h0);
        u_host.put(`ADDR_EVENT_MASK, 32'h01800000);
        u_host.put(`ADDR_MEAS_MODE, 32'h0C);
        curr_hpf = {24'h002328, 24'hFFFD44, 24'h0001F4};
        volt_hpf = {24'h002328, 24'h00012C, 24'hFFFF38};
        u_host.put(`ADDR_PEAK_CYC, 32'h2);
        zx(3'h4, 2);
        chk("irq_unsel", event_irq_line_n, 1'b1);
        zx(3'h3, 1);
        curr_hpf = {24'h002328, 24'h00000A, 24'h000258};
        chk("irq_pk", event_irq_line_n, 1'b0);
        u_host.service(`ADDR_CURRENT_PEAK, 32'h01800000, st, info);
        chk("pk_status", st, 32'h01800000);
        chk("current_peak_value_b", info, 32'h020002BC);
        u_host.get(`ADDR_VOLTAGE_PEAK, st);
        chk("voltage_peak_value_b", st, 32'h0200012C);
        zx(3'h1, 1);
        u_host.get(`ADDR_CURRENT_PEAK, st);
        chk("current_peak_value_hold", st, 32'h020002BC);
        zx(3'h1, 1);
        u_host.get(`ADDR_CURRENT_PEAK, st);
        chk("current_peak_value_a", st, 32'h01000258);
        $display("test_peak done");
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        test_regs();
        test_sag0();
        test_sag1();
        test_peak();
        test_done();
    end
endmodule
`default_nettype wire
